// *** einf_pkg.sv ***
// constants shared by the external interrupt noise filter block
// assumes clk is the high-frequency clock, so one fc period is one cycle
package einf_pkg;
    // ==========================================
    // sizes
    localparam int NUM_CH = 5;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int VEC_W  = 16;
    localparam int TH_W   = 8;

    // ==========================================
    // register offsets
    localparam logic [ADDR_W-1:0] OFS_CTRL  = 8'h37;
    localparam logic [ADDR_W-1:0] OFS_EN_LO = 8'h3a;
    localparam logic [ADDR_W-1:0] OFS_EN_HI = 8'h3b;
    localparam logic [ADDR_W-1:0] OFS_LT_LO = 8'h3c;
    localparam logic [ADDR_W-1:0] OFS_LT_HI = 8'h3d;

    // ==========================================
    // control fields
    localparam int CTL_B_FILT = 7;
    localparam int CTL_SHARED = 6;
    localparam int CTL_D_EDGE = 3;
    localparam int CTL_C_EDGE = 2;
    localparam int CTL_B_EDGE = 1;
    localparam logic [DATA_W-1:0] CTL_IMPL_MASK = 8'hce;
    localparam logic [DATA_W-1:0] CTL_RESET     = 8'h00;
    localparam logic [VEC_W-1:0]  VEC_RESET     = 16'h0000;

    // ==========================================
    // enable and latch bit positions, channels a..e
    localparam int POS_MASTER = 0;
    localparam int CH_POS [NUM_CH] = '{4, 5, 9, 14, 15};
    localparam logic [VEC_W-1:0] SRC_MASK = 16'hc230;

    // ==========================================
    // noise reject times, in clock periods as given
    localparam int FC_PER_CLK  = 1;
    localparam int T_A_REJ_FC  = 2;
    localparam int T_C_REJ_FC  = 7;
    localparam int T_B_LONG_FC = 63;
    localparam int T_B_SHRT_FC = 15;
    localparam int T_LF_REJ_FS = 1;
    localparam int CLK_HZ      = 10000000;
    localparam int FS_HZ       = 32768;
    localparam logic [TH_W-1:0] TH_A  = TH_W'(T_A_REJ_FC * FC_PER_CLK);
    localparam logic [TH_W-1:0] TH_C  = TH_W'(T_C_REJ_FC * FC_PER_CLK);
    localparam logic [TH_W-1:0] TH_BL = TH_W'(T_B_LONG_FC * FC_PER_CLK);
    localparam logic [TH_W-1:0] TH_BS = TH_W'(T_B_SHRT_FC * FC_PER_CLK);
    // two fs samples: 1/fs pulse spans at most one, 3.5/fs at least three
    localparam logic [TH_W-1:0] TH_LF = TH_W'(T_LF_REJ_FS + 1);
    localparam int FS_DIV_DEF = CLK_HZ / FS_HZ;
endpackage

// *** einf_chan_if.sv ***
// per-channel link between the controller and one pin filter
// assumes one clock domain for both ends
`timescale 1ns/100ps
interface einf_chan_if
    import einf_pkg::*;
    ();
    logic            tick;
    logic [TH_W-1:0] thresh;
    logic            fallSel;
    logic            edgeEvt;

    modport ctrl (output tick, output thresh, output fallSel, input edgeEvt);
    modport filt (input tick, input thresh, input fallSel, output edgeEvt);
endinterface

// *** einf_tick_div.sv ***
// divider giving a one-cycle enable at the low-frequency sampling rate
// assumes clk free running
`timescale 1ns/100ps
module einf_tick_div
    #(parameter int DIV = 305)
    (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
    );
    localparam int CW = $clog2(DIV + 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);

    logic [CW-1:0] cnt_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_reg <= '0;
        else if (cnt_reg == LAST)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + 1'b1;
    end

    assign tick = (cnt_reg == LAST);
endmodule

// *** einf_chan_filter.sv ***
// one pin: two-stage synchroniser, run-length noise filter, edge detector
// assumes tick, thresh and fallSel come from logic on clk
`timescale 1ns/100ps
module einf_chan_filter
    import einf_pkg::*;
    (
    input  wire logic   clk,
    input  wire logic   rst,
    input  wire logic   pin,
    einf_chan_if.filt   ch
    );
    logic            pinMeta_reg;
    logic            pinSync_reg;
    logic            filt_reg;
    logic            evt_reg;
    logic [TH_W-1:0] cnt_reg;
    logic [TH_W-1:0] cnt_next;

    // ==========================================
    // filter
    wire             differ = pinSync_reg != filt_reg;
    wire [TH_W-1:0]  cntInc = cnt_reg + 1'b1;
    wire             hit    = differ && ch.tick && (cntInc >= ch.thresh);
    // new level low is a falling edge
    wire             dirOk  = (pinSync_reg == 1'b0) == ch.fallSel;

    // any departure from the filtered level shorter than thresh samples dies
    assign cnt_next = (!differ || hit) ? '0 : (ch.tick ? cntInc : cnt_reg);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pinMeta_reg <= 1'b1;
            pinSync_reg <= 1'b1;
            filt_reg    <= 1'b1;
            cnt_reg     <= '0;
            evt_reg     <= 1'b0;
        end
        else
        begin
            pinMeta_reg <= pin;
            pinSync_reg <= pinMeta_reg;
            cnt_reg     <= cnt_next;
            if (hit)
                filt_reg <= pinSync_reg;
            evt_reg     <= hit && dirOk;
        end
    end

    assign ch.edgeEvt = evt_reg;

    // ==========================================
    // checks
    property p_run_len;
        @(posedge clk) disable iff (rst)
        $changed(filt_reg) |-> ($past(cnt_reg) + 1'b1 >= $past(ch.thresh));
    endproperty
    a_run_len: assert property (p_run_len) else $error("filter passed short pulse");

    property p_edge_dir;
        @(posedge clk) disable iff (rst)
        evt_reg |-> (filt_reg != $past(ch.fallSel)) && $changed(filt_reg);
    endproperty
    a_edge_dir: assert property (p_edge_dir) else $error("edge of wrong direction");

    property p_edge_once;
        @(posedge clk) disable iff (rst)
        evt_reg |=> !evt_reg ##1 !evt_reg;
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge event repeated");
endmodule

// *** einf_ext_irq_noise_filter.sv ***
// external interrupt conditioning: five filtered pins setting latches
// assumes clk is fc, lowFreqMode and irqAck come from logic on clk
//
// Behaviour
// - five external inputs, each noise-filtered before edge detection
// - inputs b, c, d edge select bits 1..3: 0 rising, 1 falling
// - input a falls only; ignored while shared pin select is 0
// - inputs a, e reject under 2/fc, accept 7/fc or longer
// - inputs c, d reject under 7/fc, accept 25/fc or longer
// - input b length bit 7: 0 is 63/193, 1 is 15/49 fc
// - low-frequency modes: all reject under 1/fs, accept 3.5/fs
// - latch set within establishment time plus 6/fs of clean edge
// - bit 6 selects shared pin as interrupt; port input after reset
// - new filter length for b takes effect within 26/fc
// - output activity on shared pins may raise false requests
// - reset clears control bits 7, 6 and 3..1
// - latch holds until accepted, reset or cleared by software
`timescale 1ns/100ps
module einf_ext_irq_noise_filter
    import einf_pkg::*;
    #(
    parameter int FS_DIV = FS_DIV_DEF
    )
    (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr,
    input  wire logic              rd,
    output logic      [DATA_W-1:0] rdata,
    input  wire logic [NUM_CH-1:0] pinIn,
    input  wire logic              lowFreqMode,
    input  wire logic [NUM_CH-1:0] irqAck,
    output logic                   sharedPinIsIrq,
    output logic                   irq
    );
    // ==========================================
    // state
    logic [DATA_W-1:0] ctrl_reg;
    logic [DATA_W-1:0] ctrl_next;
    logic [VEC_W-1:0]  en_reg;
    logic [VEC_W-1:0]  en_next;
    logic [VEC_W-1:0]  latch_reg;
    logic [VEC_W-1:0]  latch_next;
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    logic              fsTick;
    logic [NUM_CH-1:0] srcEvt;
    logic [NUM_CH-1:0] fallSel;
    logic [TH_W-1:0]   thFc   [NUM_CH];
    logic [TH_W-1:0]   thSel  [NUM_CH];
    logic [VEC_W-1:0]  setVec;
    logic [VEC_W-1:0]  ackVec;

    // ==========================================
    // register decode
    wire               selCtrl = addr == OFS_CTRL;
    wire               selEnLo = addr == OFS_EN_LO;
    wire               selEnHi = addr == OFS_EN_HI;
    wire               selLtLo = addr == OFS_LT_LO;
    wire               selLtHi = addr == OFS_LT_HI;

    wire               wrCtrl  = wr && selCtrl;
    wire               wrEnLo  = wr && selEnLo;
    wire               wrEnHi  = wr && selEnHi;
    wire               wrLtLo  = wr && selLtLo;
    wire               wrLtHi  = wr && selLtHi;

    // ==========================================
    // control register
    // unimplemented bits 5, 4, 0 hold zero
    assign ctrl_next = wrCtrl ? (wdata & CTL_IMPL_MASK) : ctrl_reg;

    wire               bShort   = ctrl_reg[CTL_B_FILT];
    wire               sharedOn = ctrl_reg[CTL_SHARED];

    // port logic owns the pin until bit 6 is set
    assign sharedPinIsIrq = sharedOn;

    // ==========================================
    // enable register, master enable in bit 0
    assign en_next = wrEnLo ? {en_reg[VEC_W-1:DATA_W], wdata} :
                     wrEnHi ? {wdata, en_reg[DATA_W-1:0]} :
                     en_reg;

    // ==========================================
    // channel configuration
    assign fallSel[0] = 1'b1;
    assign fallSel[1] = ctrl_reg[CTL_B_EDGE];
    assign fallSel[2] = ctrl_reg[CTL_C_EDGE];
    assign fallSel[3] = ctrl_reg[CTL_D_EDGE];
    assign fallSel[4] = 1'b1;

    assign thFc[0] = TH_A;
    // length bit steers the threshold at once, well inside 26 fc
    assign thFc[1] = bShort ? TH_BS : TH_BL;
    assign thFc[2] = TH_C;
    assign thFc[3] = TH_C;
    assign thFc[4] = TH_A;

    // ==========================================
    // sampling rate: every cycle, or the fs enable in slow and sleep
    einf_tick_div
        #(.DIV (FS_DIV))
    u_fs_div
        (
        .clk  (clk),
        .rst  (rst),
        .tick (fsTick)
        );

    wire chTick = lowFreqMode ? fsTick : 1'b1;

    // ==========================================
    // pin filters
    genvar gi;
    generate
        for (gi = 0; gi < NUM_CH; gi++)
        begin : g_ch
            einf_chan_if chIf ();

            assign thSel[gi]      = lowFreqMode ? TH_LF : thFc[gi];
            assign chIf.tick      = chTick;
            assign chIf.thresh    = thSel[gi];
            assign chIf.fallSel   = fallSel[gi];
            assign srcEvt[gi]     = chIf.edgeEvt;

            // pin is sampled whatever the port direction, so output
            // activity on a shared pin reaches the latch; mask it first
            einf_chan_filter u_filt
                (
                .clk (clk),
                .rst (rst),
                .pin (pinIn[gi]),
                .ch  (chIf.filt)
                );
        end
    endgenerate

    // ==========================================
    // latch set and clear vectors
    wire [NUM_CH-1:0] srcGated = srcEvt & {{(NUM_CH-1){1'b1}}, sharedOn};

    always_comb
    begin
        setVec = '0;
        ackVec = '0;
        for (int i = 0; i < NUM_CH; i++)
        begin
            setVec[CH_POS[i]] = srcGated[i];
            ackVec[CH_POS[i]] = irqAck[i];
        end
    end

    wire [VEC_W-1:0] swClr  = wrLtLo ? {{DATA_W{1'b0}}, wdata} :
                              wrLtHi ? {wdata, {DATA_W{1'b0}}} :
                              VEC_RESET;
    wire [VEC_W-1:0] clrVec = swClr | ackVec;

    // a new edge in the clearing cycle survives
    assign latch_next = ((latch_reg & ~clrVec) | setVec) & SRC_MASK;

    // ==========================================
    // interrupt output
    wire [VEC_W-1:0] pendVec = latch_reg & en_reg & SRC_MASK;
    assign irq = en_reg[POS_MASTER] && (pendVec != VEC_RESET);

    // ==========================================
    // read port, data only in the cycle after the strobe
    wire [DATA_W-1:0] rdMux = selCtrl ? ctrl_reg :
                              selEnLo ? en_reg[DATA_W-1:0] :
                              selEnHi ? en_reg[VEC_W-1:DATA_W] :
                              selLtLo ? latch_reg[DATA_W-1:0] :
                              selLtHi ? latch_reg[VEC_W-1:DATA_W] :
                              CTL_RESET;
    assign rdata_next = rd ? rdMux : CTL_RESET;
    assign rdata      = rdata_reg;

    // ==========================================
    // registers
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg  <= CTL_RESET;
            en_reg    <= VEC_RESET;
            latch_reg <= VEC_RESET;
            rdata_reg <= CTL_RESET;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            en_reg    <= en_next;
            latch_reg <= latch_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================
    // checks
    wire [VEC_W-1:0] keepVec = latch_reg & ~clrVec;

    property p_latch_set;
        @(posedge clk) disable iff (rst)
        (setVec != VEC_RESET) |=> ((latch_reg & $past(setVec)) == $past(setVec));
    endproperty
    a_latch_set: assert property (p_latch_set) else $error("edge did not set latch");

    property p_latch_hold;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((latch_reg & $past(keepVec)) == $past(keepVec));
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latch dropped");

    property p_latch_clr;
        @(posedge clk) disable iff (rst)
        (clrVec != VEC_RESET) |=>
            ((latch_reg & $past(clrVec) & ~$past(setVec)) == VEC_RESET);
    endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("latch not cleared");

    property p_shared_gate;
        @(posedge clk) disable iff (rst)
        !sharedOn |-> !setVec[CH_POS[0]];
    endproperty
    a_shared_gate: assert property (p_shared_gate) else $error("a latched when port");

    property p_ctrl_unused;
        @(posedge clk) disable iff (rst)
        wrCtrl |=> ((ctrl_reg & ~CTL_IMPL_MASK) == CTL_RESET) && (ctrl_reg != ~CTL_RESET);
    endproperty
    a_ctrl_unused: assert property (p_ctrl_unused) else $error("control bits wrong");

    property p_th_fast;
        @(posedge clk) disable iff (rst)
        !lowFreqMode |-> (thSel[0] == 8'h02) && (thSel[4] == 8'h02) && chTick;
    endproperty
    a_th_fast: assert property (p_th_fast) else $error("a/e length wrong");

    property p_th_cd;
        @(posedge clk) disable iff (rst)
        !lowFreqMode |-> (thSel[2] == 8'h07) && (thSel[3] == 8'h07);
    endproperty
    a_th_cd: assert property (p_th_cd) else $error("c/d length wrong");

    property p_th_b;
        @(posedge clk) disable iff (rst)
        $changed(bShort) && !lowFreqMode |-> ##[0:25]
            (thSel[1] == (bShort ? 8'h0f : 8'h3f));
    endproperty
    a_th_b: assert property (p_th_b) else $error("b length not applied");

    property p_th_slow;
        @(posedge clk) disable iff (rst)
        lowFreqMode |-> (thSel[1] == 8'h02) && (thSel[2] == 8'h02) && (chTick == fsTick);
    endproperty
    a_th_slow: assert property (p_th_slow) else $error("slow length wrong");

    property p_shared_sel;
        @(posedge clk) disable iff (rst)
        wrCtrl |=> (sharedPinIsIrq == $past(wdata[CTL_SHARED]));
    endproperty
    a_shared_sel: assert property (p_shared_sel) else $error("pin function wrong");

    property p_rd_once;
        @(posedge clk) disable iff (rst)
        !rd |=> (rdata == CTL_RESET);
    endproperty
    a_rd_once: assert property (p_rd_once) else $error("read data outside slot");

    // ==========================================
    // register and output checks
    property p_latch_only_src;
        @(posedge clk) disable iff (rst)
        (latch_reg & ~SRC_MASK) == VEC_RESET;
    endproperty
    a_latch_only_src: assert property (p_latch_only_src) else $error("latch outside sources");

    property p_latch_cause;
        @(posedge clk) disable iff (rst)
        1'b1 |=> ((latch_reg & ~$past(latch_reg) & ~$past(setVec)) == VEC_RESET);
    endproperty
    a_latch_cause: assert property (p_latch_cause) else $error("latch set without edge");

    property p_ctrl_hold;
        @(posedge clk) disable iff (rst)
        !wrCtrl |=> $stable(ctrl_reg);
    endproperty
    a_ctrl_hold: assert property (p_ctrl_hold) else $error("control changed unwritten");

    property p_en_hold;
        @(posedge clk) disable iff (rst)
        !(wrEnLo || wrEnHi) |=> $stable(en_reg);
    endproperty
    a_en_hold: assert property (p_en_hold) else $error("enable changed unwritten");

    property p_irq_master;
        @(posedge clk) disable iff (rst)
        !en_reg[POS_MASTER] |-> !irq;
    endproperty
    a_irq_master: assert property (p_irq_master) else $error("irq without master enable");

    property p_irq_pend;
        @(posedge clk) disable iff (rst)
        irq |-> ((latch_reg & en_reg & SRC_MASK) != VEC_RESET);
    endproperty
    a_irq_pend: assert property (p_irq_pend) else $error("irq without pending source");

    property p_ack_clr;
        @(posedge clk) disable iff (rst)
        irqAck[NUM_CH-1] && !srcGated[NUM_CH-1] |=> !latch_reg[CH_POS[NUM_CH-1]];
    endproperty
    a_ack_clr: assert property (p_ack_clr) else $error("accepted latch kept");

    property p_rd_ctrl;
        @(posedge clk) disable iff (rst)
        rd && selCtrl |=> (rdata == $past(ctrl_reg));
    endproperty
    a_rd_ctrl: assert property (p_rd_ctrl) else $error("control read wrong");

    property p_rd_unmapped;
        @(posedge clk) disable iff (rst)
        rd && !(selCtrl || selEnLo || selEnHi || selLtLo || selLtHi) |=> (rdata == CTL_RESET);
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");

    property p_edge_cfg;
        @(posedge clk) disable iff (rst)
        fallSel[0] && fallSel[NUM_CH-1];
    endproperty
    a_edge_cfg: assert property (p_edge_cfg) else $error("a/e not falling only");
endmodule

// *** einf_pin_src.sv ***
// external signal sources driving the five interrupt pins
// assumes pins idle high; every change lands just after a rising edge
`timescale 1ns/100ps
module einf_pin_src
    import einf_pkg::*;
    (
    input  wire logic              clk,
    output logic      [NUM_CH-1:0] pinIn
    );
    // sources only make clean steps, so a single edge per change
    initial pinIn = '1;

    task automatic hold(input int ch, input logic v);
        @(posedge clk);
        pinIn[ch] <= v;
    endtask

    // low pulse of len cycles, then back to idle high
    task automatic pulse(input int ch, input int len);
        hold(ch, 1'b0);
        repeat (len) @(posedge clk);
        pinIn[ch] <= 1'b1;
    endtask
endmodule

// *** tb.sv ***
// self-checking bench for the external interrupt noise filter
// assumes a 10 MHz clock and a small fs divider to keep runs short
`timescale 1ns/100ps
module tb;
    import einf_pkg::*;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [NUM_CH-1:0] pinIn;
    logic              lowFreqMode = 1'b0;
    logic [NUM_CH-1:0] irqAck = '0;
    logic              sharedPinIsIrq;
    logic              irq;
    int                err_count = 0;
    int                samples_checked = 0;
    logic [VEC_W-1:0]  v;
    logic [DATA_W-1:0] d;
    logic [DATA_W-1:0] ctl;
    int                tCh  [7] = '{0, 4, 2, 3, 1, 1, 0};
    logic [7:0]        tCtl [7] = '{8'h40, 8'h40, 8'h04, 8'h08, 8'h02, 8'h82, 8'h00};
    int                tRej [7] = '{2, 2, 7, 7, 63, 15, 8};
    int                tAcc [7] = '{7, 7, 25, 25, 193, 49, 7};

    always #50 clk = ~clk;

    einf_ext_irq_noise_filter #(.FS_DIV(4)) dut (
        .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pinIn(pinIn), .lowFreqMode(lowFreqMode), .irqAck(irqAck),
        .sharedPinIsIrq(sharedPinIsIrq), .irq(irq)
    );
    einf_pin_src src (.clk(clk), .pinIn(pinIn));

    task automatic chk(input logic [VEC_W-1:0] got, input logic [VEC_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wrReg(input logic [7:0] a, input logic [7:0] dat);
        @(posedge clk);
        addr <= a;
        wdata <= dat;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // data only stand in the cycle after the strobe
    task automatic rdReg(input logic [7:0] a, output logic [7:0] dat);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 dat = rdata;
    endtask

    task automatic rdLatch(output logic [15:0] vec);
        rdReg(OFS_LT_LO, vec[7:0]);
        rdReg(OFS_LT_HI, vec[15:8]);
    endtask

    task automatic clrLatch();
        wrReg(OFS_LT_LO, 8'hff);
        wrReg(OFS_LT_HI, 8'hff);
    endtask

    function automatic logic [15:0] bitOf(input int ch);
        return 16'h0001 << CH_POS[ch];
    endfunction

    // a falls only and needs the shared pin select; e falls only
    function automatic logic [15:0] expSet(input logic [7:0] c, input int ch, input logic fell);
        if (ch == 0)
            return (fell && c[CTL_SHARED]) ? bitOf(ch) : 16'h0000;
        if (ch == 4)
            return fell ? bitOf(ch) : 16'h0000;
        return (c[ch] == fell) ? bitOf(ch) : 16'h0000;
    endfunction

    task automatic results();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        results();
    end

    initial
    begin
        void'($urandom(76344));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // ==========================================
        // reset state and register map
        rdReg(OFS_CTRL, d);
        chk({8'h00, d}, {8'h00, CTL_RESET});
        chk({15'h0, sharedPinIsIrq}, 16'h0000);
        rdLatch(v);
        chk(v, VEC_RESET);
        wrReg(8'h30, 8'hff);
        rdReg(8'h30, d);
        chk({8'h00, d}, 16'h0000);
        ctl = 8'($urandom);
        wrReg(OFS_EN_HI, ctl);
        rdReg(OFS_EN_HI, d);
        chk({8'h00, d}, {8'h00, ctl});
        wrReg(OFS_EN_HI, 8'h00);
        // ==========================================
        // edge selection, random control values
        repeat (4)
        begin
            ctl = 8'($urandom);
            wrReg(OFS_CTRL, ctl);
            rdReg(OFS_CTRL, d);
            chk({8'h00, d}, {8'h00, ctl & CTL_IMPL_MASK});
            chk({15'h0, sharedPinIsIrq}, {15'h0, ctl[CTL_SHARED]});
            for (int ch = 0; ch < NUM_CH; ch++)
            begin
                src.hold(ch, 1'b0);
                repeat (300) @(posedge clk);
                rdLatch(v);
                chk(v, expSet(ctl, ch, 1'b1));
                clrLatch();
                src.hold(ch, 1'b1);
                repeat (300) @(posedge clk);
                rdLatch(v);
                chk(v, expSet(ctl, ch, 1'b0));
                clrLatch();
            end
        end
        // ==========================================
        // filter lengths: just below reject figure, then accept figure plus 0 to 3 cycles
        for (int k = 0; k < 7; k++)
        begin
            wrReg(OFS_CTRL, tCtl[k]);
            repeat (26) @(posedge clk);
            src.pulse(tCh[k], tRej[k] - 1);
            repeat (300) @(posedge clk);
            rdLatch(v);
            chk(v, 16'h0000);
            src.pulse(tCh[k], tAcc[k] + int'($urandom % 4));
            repeat (300) @(posedge clk);
            rdLatch(v);
            chk(v, expSet(tCtl[k], tCh[k], 1'b1));
            clrLatch();
        end
        // ==========================================
        // slow mode: fs period is four cycles here
        wrReg(OFS_CTRL, 8'h04);
        lowFreqMode <= 1'b1;
        src.pulse(2, 3);
        repeat (100) @(posedge clk);
        rdLatch(v);
        chk(v, 16'h0000);
        src.pulse(2, 14);
        repeat (100) @(posedge clk);
        rdLatch(v);
        chk(v, bitOf(2));
        clrLatch();
        lowFreqMode <= 1'b0;
        // ==========================================
        // interrupt output: raise, mask, hold, clear
        wrReg(OFS_CTRL, 8'h40);
        wrReg(OFS_EN_LO, 8'h11);
        src.pulse(0, 7);
        repeat (20) @(posedge clk);
        #1 chk({15'h0, irq}, 16'h0001);
        wrReg(OFS_EN_LO, 8'h01);
        #1 chk({15'h0, irq}, 16'h0000);
        wrReg(OFS_LT_LO, 8'h00);
        wrReg(OFS_EN_LO, 8'h11);
        repeat (200) @(posedge clk);
        #1 chk({15'h0, irq}, 16'h0001);
        @(posedge clk);
        irqAck <= 5'h01;
        @(posedge clk);
        irqAck <= 5'h00;
        rdLatch(v);
        chk(v, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        src.pulse(0, 7);
        repeat (20) @(posedge clk);
        wrReg(OFS_LT_LO, 8'h10);
        #1 chk({15'h0, irq}, 16'h0000);
        results();
    end
endmodule
